/* core/metering_sample_path.sv */
`timescale 1ns/1ps
`default_nettype none
module metering_sample_path
  import meter_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
) (
  input  wire logic                 i_sys_clk,  // 200 MHz DSP clock
  input  wire logic                 i_rst_n,    // Async reset, low
  input  wire logic [NCH-1:0][23:0] i_adc_data, // Decimator words, held
  input  wire logic                 i_ss_n,     // Serial select pin
  input  wire logic                 i_sclk,     // Serial clock pin
  input  wire logic                 i_mosi,     // Serial data in pin
  output logic                      o_miso,     // Serial data out
  output logic                      o_miso_oe,  // Serial data out enable
  output logic                      o_irq0_n    // Interrupt, low
);
  reg_access_if bus ();

  logic [15:0]          cnt;
  logic                 tick;
  logic                 cap_done;
  logic [23:0]          gain [NGAIN];
  logic [23:0]          coef;
  logic                 phase_int_en;
  logic                 neutral_int_en;
  logic                 dcf_en;
  logic                 ready_flag;
  logic                 ready_mask;
  logic [NCH-1:0][23:0] sample;
  logic [31:0]          next_rdata;
  logic                 clr_ready;

  // Internal word layouts on the serial side
  function automatic logic [31:0] fmt28(input logic [23:0] v);
    return {4'h0, {4{v[23]}}, v};
  endfunction

  function automatic logic [31:0] fmt32(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction

  function automatic logic is_addr(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  // Serial pins to register accesses
  serial_port u_port (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_ss_n    (i_ss_n),
    .i_sclk    (i_sclk),
    .i_mosi    (i_mosi),
    .o_miso    (o_miso),
    .o_miso_oe (o_miso_oe),
    .bus       (bus.master)
  );

  // Sample-rate divider; all channels share one strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt == 16'(SAMPLE_CYCLES - 1)) begin
      cnt  <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // Capture lands one edge after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) cap_done <= 1'b0;
    else cap_done <= tick;
  end

  // One processing chain per channel; voltages run at unity gain
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic [23:0] ch_gain;
    logic        ch_int;
    if (ch < NGAIN) begin : g_cur
      assign ch_gain = gain[ch];
      assign ch_int  = (ch == NEUT_CH) ? neutral_int_en : phase_int_en;
    end else begin : g_volt
      assign ch_gain = GAIN_RST;
      assign ch_int  = 1'b0;
    end
    sample_stage u_stage (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_tick    (tick),
      .i_x       (i_adc_data[ch]),
      .i_gain    (ch_gain),
      .i_int_en  (ch_int),
      .i_coef    (coef),
      .i_dcf_en  (dcf_en),
      .o_y       (sample[ch])
    );
  end

  // Gain registers, low 24 bits of the word are kept
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NGAIN; i++) gain[i] <= GAIN_RST;
    end else if (bus.wr) begin
      for (int i = 0; i < NGAIN; i++) begin
        if (is_addr(bus.addr, A_GAIN0 + 16'(i))) gain[i] <= bus.wdata[23:0];
      end
    end
  end

  // Integrator coefficient; must be loaded before an enable
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) coef <= COEF_RST;
    else if (bus.wr && is_addr(bus.addr, A_COEF)) begin
      coef <= bus.wdata[23:0];
    end
  end

  // Configuration bits
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_int_en   <= INT_EN_RST;
      neutral_int_en <= INT_EN_RST;
      dcf_en         <= DCF_EN_RST;
    end else if (bus.wr) begin
      if (is_addr(bus.addr, A_CONFIG)) begin
        phase_int_en <= bus.wdata[PINT_BIT];
      end else if (is_addr(bus.addr, A_SETUP3)) begin
        dcf_en         <= bus.wdata[DCF_EN_BIT];
        neutral_int_en <= bus.wdata[NINT_BIT];
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) ready_mask <= 1'b0;
    else if (bus.wr && is_addr(bus.addr, A_MASK)) begin
      ready_mask <= bus.wdata[READY_BIT];
    end
  end

  // Sample-ready flag; write one to clear, a new capture wins
  assign clr_ready = bus.wr && is_addr(bus.addr, A_STATUS) && bus.wdata[READY_BIT];
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) ready_flag <= 1'b0;
    else if (cap_done) ready_flag <= 1'b1;
    else if (clr_ready) ready_flag <= 1'b0;
  end

  // Interrupt pin is registered so it never glitches
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_irq0_n <= 1'b1;
    else o_irq0_n <= !(ready_flag && ready_mask);
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (bus.addr >= A_GAIN0 && bus.addr < A_GAIN0 + 16'(NGAIN)) begin
      next_rdata = fmt28(gain[bus.addr[1:0]]);
    end else if (is_addr(bus.addr, A_COEF)) begin
      next_rdata = fmt28(coef);
    end else if (is_addr(bus.addr, A_CONFIG)) begin
      next_rdata[PINT_BIT] = phase_int_en;
    end else if (is_addr(bus.addr, A_SETUP3)) begin
      next_rdata[DCF_EN_BIT] = dcf_en;
      next_rdata[NINT_BIT]   = neutral_int_en;
    end else if (is_addr(bus.addr, A_STATUS)) begin
      next_rdata[READY_BIT] = ready_flag;
    end else if (is_addr(bus.addr, A_MASK)) begin
      next_rdata[READY_BIT] = ready_mask;
    end else if (bus.addr >= A_SAMPLE0 && bus.addr < A_SAMPLE0 + 16'(NCH)) begin
      next_rdata = fmt32(sample[3'(bus.addr - A_SAMPLE0)]);
    end
  end

  // Read data is held until the next read
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) bus.rdata <= 32'h00000000;
    else if (bus.rd) bus.rdata <= next_rdata;
  end

  // Strobe, capture and flag in sequence
  sequence s_strobe;
    tick;
  endsequence

  sequence s_captured;
    ##1 cap_done ##1 ready_flag;
  endsequence

  sequence s_irq_raised;
    ##1 !o_irq0_n;
  endsequence

  a_tick_spacing: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tick |=> !tick [*8])
    else $error("sample strobes too close");

  a_flag_after_capture: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_strobe |-> s_captured)
    else $error("sample-ready flag not set after capture");

  a_irq_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ready_flag && ready_mask |-> s_irq_raised)
    else $error("interrupt not raised for masked-in flag");

  a_irq_masked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !ready_mask ##1 !ready_mask |-> o_irq0_n)
    else $error("interrupt raised while masked");

  a_flag_set_wins: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cap_done && clr_ready |=> ready_flag)
    else $error("capture lost against a clear");

  a_flag_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    clr_ready && !cap_done |=> !ready_flag)
    else $error("flag not cleared by write of one");

  a_gain_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    bus.wr && is_addr(bus.addr, A_GAIN0) |=> gain[0] == $past(bus.wdata[23:0]))
    else $error("gain write not stored");

  a_gain_fmt: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    bus.rd && is_addr(bus.addr, A_GAIN0) |=>
    bus.rdata[31:28] == 4'h0 && bus.rdata[27:24] == {4{bus.rdata[23]}}
    && bus.rdata[23:0] == gain[0])
    else $error("gain read format wrong");

  a_coef_fmt: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    bus.rd && is_addr(bus.addr, A_COEF) && coef == 24'hFF8000 |=>
    bus.rdata == 32'h0FFF8000)
    else $error("coefficient read format wrong");

  a_sample_fmt: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    bus.rd && bus.addr >= A_SAMPLE0 && bus.addr < A_SAMPLE0 + 16'(NCH) |=>
    bus.rdata[31:24] == {8{bus.rdata[23]}})
    else $error("sample read not sign-extended");

  a_unity_path: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tick && !dcf_en && !phase_int_en && gain[0] == GAIN_RST && i_adc_data[0] == FS_POS
    |=> sample[0] == FS_POS)
    else $error("full-scale code altered at unity gain");

  a_voltage_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tick && !dcf_en ##1 1'b1 |-> sample[4] == $past(i_adc_data[4]) ##1 ready_flag)
    else $error("voltage capture not flagged");
endmodule
`default_nettype wire

/* core/meter_pkg.sv */
`default_nettype none
package meter_pkg;
  // Sample path geometry
  localparam int DW      = 24;
  localparam int NCH     = 7;          // IA, IB, IC, IN, VA, VB, VC
  localparam int NGAIN   = 4;          // Current channels with a gain
  localparam int NEUT_CH = 3;
  // Sample rate
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned SAMPLE_HZ  = 8000;
  localparam int unsigned SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  // Nominal full-scale codes
  localparam logic [23:0] FS_POS = 24'h514791;
  localparam logic [23:0] FS_NEG = 24'hAEB86F;
  // Arithmetic
  localparam int GAIN_FRAC = 23;
  localparam int DCF_SHIFT = 10;
  // Reset values
  localparam logic [23:0] GAIN_RST  = 24'h000000;
  localparam logic [23:0] COEF_RST  = 24'h000000;
  localparam logic        DCF_EN_RST = 1'b1;
  localparam logic        INT_EN_RST = 1'b0;
  // Field positions
  localparam int PINT_BIT   = 0;
  localparam int DCF_EN_BIT = 0;
  localparam int NINT_BIT  = 3;
  localparam int READY_BIT = 17;
  // Register addresses
  localparam logic [15:0] A_GAIN0   = 16'h0010;
  localparam logic [15:0] A_COEF    = 16'h0014;
  localparam logic [15:0] A_CONFIG  = 16'h0020;
  localparam logic [15:0] A_SETUP3  = 16'h0021;
  localparam logic [15:0] A_STATUS  = 16'h0030;
  localparam logic [15:0] A_MASK    = 16'h0031;
  localparam logic [15:0] A_SAMPLE0 = 16'h0040;
  // Serial commands
  localparam logic [7:0] CMD_RD = 8'h01;
  localparam logic [7:0] CMD_WR = 8'h00;

  // Sign extension to the working width
  function automatic logic signed [49:0] sx50(input logic [23:0] v);
    return {{26{v[23]}}, v};
  endfunction

  // Clamp to the signed 24-bit range
  function automatic logic [23:0] sat24(input logic signed [49:0] v);
    if (v > 50'sh7FFFFF) return 24'h7FFFFF;
    else if (v < -50'sh800000) return 24'h800000;
    else return v[23:0];
  endfunction
endpackage
`default_nettype wire

/* core/reg_access_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic        rd;     // Read pulse
  logic        wr;     // Write pulse
  logic [15:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;  // Valid the cycle after rd
  modport master (output rd, wr, addr, wdata, input rdata);
  modport slave  (input rd, wr, addr, wdata, output rdata);
endinterface
`default_nettype wire

/* core/sample_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module sample_stage
  import meter_pkg::*;
(
  input  wire logic        i_sys_clk, // System clock
  input  wire logic        i_rst_n,   // Async reset, low
  input  wire logic        i_tick,    // Sample strobe
  input  wire logic [23:0] i_x,       // ADC word
  input  wire logic [23:0] i_gain,    // Gain word
  input  wire logic        i_int_en,  // Integrator on
  input  wire logic [23:0] i_coef,    // Integrator coefficient
  input  wire logic        i_dcf_en,  // DC filter on
  output logic      [23:0] o_y        // Captured sample
);
  logic signed [49:0] prod;
  logic signed [49:0] leak;
  logic [23:0] g;
  logic [23:0] yi;
  logic [23:0] yh;
  logic [23:0] ip;
  logic [23:0] xp;
  logic [23:0] hp;

  // Gain, integrator, filter in fixed order
  always_comb begin
    prod = sx50(i_x) * sx50(i_gain);
    g    = sat24(sx50(i_x) + (prod >>> GAIN_FRAC));
    leak = sx50(ip) * sx50(i_coef);
    if (i_int_en) yi = sat24(sx50(g) + sx50(ip) + (leak >>> GAIN_FRAC));
    else yi = g;
    if (i_dcf_en) yh = sat24(sx50(yi) - sx50(xp) + sx50(hp) - (sx50(hp) >>> DCF_SHIFT));
    else yh = yi;
  end

  // Integrator state and hp are cleared while a stage is bypassed; xp always follows yi
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ip  <= 24'h000000;
      xp  <= 24'h000000;
      hp  <= 24'h000000;
      o_y <= 24'h000000;
    end else if (i_tick) begin
      ip  <= i_int_en ? yi : 24'h000000;
      xp  <= yi;
      hp  <= i_dcf_en ? yh : 24'h000000;
      o_y <= yh;
    end
  end

  a_bypass_order: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_tick && !i_int_en && !i_dcf_en |=> o_y == $past(g))
    else $error("bypassed stages do not pass the gain output");
  a_gain_clamp: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_tick && !i_int_en && !i_dcf_en && !i_x[23] && !i_gain[23] && i_x > 24'h600000
    && i_gain > 24'h600000 |=> o_y == 24'h7FFFFF)
    else $error("positive overflow not clamped");
endmodule
`default_nettype wire

/* core/serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_port
  import meter_pkg::*;
(
  input  wire logic   i_sys_clk, // System clock
  input  wire logic   i_rst_n,   // Async reset, low
  input  wire logic   i_ss_n,    // Select pin, low
  input  wire logic   i_sclk,    // Serial clock pin
  input  wire logic   i_mosi,    // Data in pin
  output logic        o_miso,    // Data out
  output logic        o_miso_oe, // Data out enable
  reg_access_if.master bus       // Register access
);
  logic [2:0] ss_s;
  logic [2:0] ck_s;
  logic [1:0] mo_s;
  logic [55:0] sh;
  logic [55:0] next_sh;
  logic [5:0] cnt;
  logic [31:0] tx;
  logic load;
  logic skip;
  logic rise;
  logic fall;

  // Pin synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ss_s <= 3'h7;
      ck_s <= 3'h7;
      mo_s <= 2'h0;
    end else begin
      ss_s <= {ss_s[1:0], i_ss_n};
      ck_s <= {ck_s[1:0], i_sclk};
      mo_s <= {mo_s[0], i_mosi};
    end
  end
  assign rise    = ck_s[1] && !ck_s[2] && !ss_s[1];
  assign fall    = !ck_s[1] && ck_s[2] && !ss_s[1];
  assign next_sh = {sh[54:0], mo_s[1]};

  // Command, address, data framing
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh        <= 56'h0;
      cnt       <= 6'h0;
      bus.rd    <= 1'b0;
      bus.wr    <= 1'b0;
      bus.addr  <= 16'h0000;
      bus.wdata <= 32'h00000000;
    end else begin
      bus.rd <= 1'b0;
      bus.wr <= 1'b0;
      if (ss_s[1]) begin
        cnt <= 6'h0;
      end else if (rise) begin
        sh  <= next_sh;
        cnt <= cnt + 6'h1;
        if (cnt == 6'd23 && next_sh[23:16] == CMD_RD) begin
          bus.rd   <= 1'b1;
          bus.addr <= next_sh[15:0];
        end
        if (cnt == 6'd55 && next_sh[55:48] == CMD_WR) begin
          bus.wr    <= 1'b1;
          bus.addr  <= next_sh[47:32];
          bus.wdata <= next_sh[31:0];
        end
      end
    end
  end

  // Read word shifts out MSB first on falling edges
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load      <= 1'b0;
      skip      <= 1'b0;
      tx        <= 32'h00000000;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      load      <= bus.rd;
      o_miso    <= tx[31];
      o_miso_oe <= !ss_s[1];
      if (ss_s[1]) begin
        tx <= 32'h00000000;
      end else if (load) begin
        tx   <= bus.rdata;
        skip <= 1'b1;   // Falling edge after bit 24 precedes the first data bit
      end else if (fall) begin
        if (skip) skip <= 1'b0;
        else tx <= {tx[30:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
  parameter int HALF = 10
) (
  input  wire logic i_sys_clk, // System clock
  output logic      o_ss_n,    // Select, low
  output logic      o_sclk,    // Serial clock, idles high
  output logic      o_mosi,    // Data to device
  input  wire logic i_miso,    // Data from device
  input  wire logic i_miso_oe  // Device drives data
);
  // Idle bus at time zero
  initial begin
    o_ss_n = 1'b1;
    o_sclk = 1'b1;
    o_mosi = 1'b0;
  end

  // One whole frame, MSB first; half period kept well above the sync delay
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
    logic [55:0] frame;
    frame = {cmd, addr, wdata};
    rdata = 32'h00000000;
    @(posedge i_sys_clk);
    o_ss_n <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    for (int i = 55; i >= 0; i--) begin
      @(posedge i_sys_clk);
      o_sclk <= 1'b0;
      o_mosi <= frame[i];
      repeat (HALF) @(posedge i_sys_clk);
      // Taken at the rising edge; an undriven line poisons the word
      if (i < 32) rdata = {rdata[30:0], i_miso_oe ? i_miso : 1'bx};
      o_sclk <= 1'b1;
      repeat (HALF - 1) @(posedge i_sys_clk);
    end
    @(posedge i_sys_clk);
    o_ss_n <= 1'b1;
    o_mosi <= ~o_mosi; // Released line must not keep its last value
    repeat (6) @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

/* testbench/metering_channel_sample_path_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module metering_channel_sample_path_tb
  import meter_pkg::*;
;
  localparam int SC = 32;
  localparam logic [23:0] GTAB [4] = '{24'h7FFFFF, 24'h7FFFFF, 24'hC00000, 24'h400000};

  logic                 sys_clk;
  logic                 rst_n;
  logic [NCH-1:0][23:0] adc;
  logic                 ss_n;
  logic                 sclk;
  logic                 mosi;
  logic                 miso;
  logic                 miso_oe;
  logic                 irq_n;
  int                   err_count;
  int                   cmp_count;
  int                   seed;
  int                   x;
  logic [23:0]          gain_m [NGAIN];
  logic [23:0]          e;
  logic [31:0]          r;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  metering_sample_path #(
    .SAMPLE_CYCLES(SC)
  ) i_metering_sample_path (
    .i_sys_clk (sys_clk),
    .i_rst_n   (rst_n),
    .i_adc_data(adc),
    .i_ss_n    (ss_n),
    .i_sclk    (sclk),
    .i_mosi    (mosi),
    .o_miso    (miso),
    .o_miso_oe (miso_oe),
    .o_irq0_n  (irq_n)
  );

  spi_host_model i_spi_host_model (
    .i_sys_clk(sys_clk),
    .o_ss_n   (ss_n),
    .o_sclk   (sclk),
    .o_mosi   (mosi),
    .i_miso   (miso),
    .i_miso_oe(miso_oe)
  );

  // Single comparison point
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Reference gain stage: floor shift, clamp instead of wrap
  function automatic logic [23:0] gain_ref(input logic [23:0] v, input logic [23:0] g);
    longint p;
    p = longint'($signed(v)) + ((longint'($signed(v)) * longint'($signed(g))) >>> 23);
    if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
    else if (p < -64'sh800000) p = -64'sh800000;
    return p[23:0];
  endfunction

  function automatic logic [31:0] sx32(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    i_spi_host_model.xfer(CMD_WR, a, d, dummy);
  endtask

  task automatic rdc(input string n, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_spi_host_model.xfer(CMD_RD, a, 32'h00000000, q);
    check(n, q, exp);
  endtask

  // Watchdog: about 1.7 times the expected run of some 40 frames
  initial begin
    #400_000;
    err_count++;
    finish_test();
  end

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    adc = '0;
    err_count = 0;
    cmp_count = 0;
    seed = 32'hEF087AD6;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Reset values and an unmapped place
    check("irq idle", {31'h0, irq_n}, 32'h00000001);
    rdc("config", A_CONFIG, 32'h00000000);
    rdc("setup3", A_SETUP3, 32'h00000001);
    rdc("coef", A_COEF, 32'h00000000);
    rdc("unmapped", 16'h0099, 32'h00000000);
    // Gains against full-scale and random codes, filter bypassed
    wr(A_SETUP3, 32'h00000000);
    adc[0] <= FS_POS;
    adc[1] <= FS_NEG;
    for (int i = 2; i < NCH; i++) begin
      x = $random(seed) % 5326738;
      adc[i] <= x[23:0];
    end
    for (int i = 0; i < NGAIN; i++) begin
      gain_m[i] = GTAB[i];
      wr(A_GAIN0 + 16'(i), {8'h00, GTAB[i]});
      rdc("gain", A_GAIN0 + 16'(i), {4'h0, {4{GTAB[i][23]}}, GTAB[i]});
    end
    repeat (2 * SC + 8) @(posedge sys_clk);
    for (int i = 0; i < NCH; i++) begin
      e = (i < NGAIN) ? gain_ref(adc[i], gain_m[i]) : adc[i];
      rdc("sample", A_SAMPLE0 + 16'(i), sx32(e));
    end
    // Read-only sample place ignores writes
    wr(A_SAMPLE0, 32'h00000000);
    rdc("sample ro", A_SAMPLE0, sx32(gain_ref(adc[0], gain_m[0])));
    // Coefficient loaded; no effect while integrators are off; top code overflows
    adc[0] <= 24'h7FFFFF;
    wr(A_COEF, 32'h0FFF8000);
    rdc("coef", A_COEF, 32'h0FFF8000);
    rdc("coef idle", A_SAMPLE0 + 16'h0001, sx32(gain_ref(adc[1], gain_m[1])));
    rdc("clamp", A_SAMPLE0, 32'h007FFFFF);
    // Unity gain keeps the full-scale code
    adc[0] <= FS_POS;
    wr(A_GAIN0, 32'h00000000);
    rdc("unity", A_SAMPLE0, sx32(FS_POS));
    // Phase integrator only, then neutral as well
    adc[0] <= 24'h100000;
    adc[3] <= 24'h100000;
    wr(A_GAIN0 + 16'h0003, 32'h00000000);
    wr(A_CONFIG, 32'h00000001);
    rdc("config", A_CONFIG, 32'h00000001);
    rdc("ia integ", A_SAMPLE0, 32'h007FFFFF);
    rdc("in plain", A_SAMPLE0 + 16'h0003, 32'h00100000);
    wr(A_SETUP3, 32'h00000008);
    rdc("in integ", A_SAMPLE0 + 16'h0003, 32'h007FFFFF);
    // DC filter back on, then a step: the new dc level must start to decay
    wr(A_CONFIG, 32'h00000000);
    wr(A_SETUP3, 32'h00000001);
    adc[0] <= 24'h200000;
    i_spi_host_model.xfer(CMD_RD, A_SAMPLE0, 32'h00000000, r);
    check("dc decay", {31'h0, ($signed(r) < 32'sh00100000) && ($signed(r) > 0)}, 32'h00000001);
    // Sample-ready flag and its mask
    i_spi_host_model.xfer(CMD_RD, A_STATUS, 32'h00000000, r);
    check("ready flag", {31'h0, r[READY_BIT]}, 32'h00000001);
    check("irq masked", {31'h0, irq_n}, 32'h00000001);
    wr(A_MASK, 32'h00020000);
    repeat (SC + 4) @(posedge sys_clk);
    check("irq on", {31'h0, irq_n}, 32'h00000000);
    wr(A_STATUS, 32'h00020000);
    wr(A_MASK, 32'h00000000);
    repeat (4) @(posedge sys_clk);
    check("irq off", {31'h0, irq_n}, 32'h00000001);
    finish_test();
  end
endmodule
`default_nettype wire
